// File: tb/dual_timer_counter_properties.sv
// checker for the dual timer/counter register port and overflow flags
// assumes it is bound to dual_timer_counter and sees only its ports
`timescale 1ns/1ps
module dual_timer_counter_properties
  import dual_timer_pkg::*;
(
  // clock and reset
  input wire logic              clk_i,
  input wire logic              rstn_i,
  // register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  // pins
  input wire logic              ext_irq0_pin_i,
  input wire logic              ext_irq1_pin_i,
  input wire logic              t0_count_pin_i,
  input wire logic              t1_count_pin_i,
  input wire logic              slow_clk_i,
  // flags
  input wire logic              t0_vector_ack_i,
  input wire logic              t1_vector_ack_i,
  input wire logic              t0_overflow_flag_o,
  input wire logic              t1_overflow_flag_o
);
  // ----------------------------------------------------------------
  // shadow of bits only software changes
  // ----------------------------------------------------------------
  logic [7:0] mode_reg;
  logic [7:0] aux_reg;
  logic [1:0] run_reg;
  logic       mapped;
  assign mapped = addr_i inside {OFS_RUN_FLAGS, OFS_MODE, OFS_T0_LOW, OFS_T1_LOW, OFS_T0_HIGH, OFS_T1_HIGH, OFS_AUX_ONE};
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      mode_reg <= 8'h00;
      aux_reg  <= 8'h00;
      run_reg  <= 2'b00;
    end else if (wr_i) begin
      if (addr_i == OFS_MODE) mode_reg <= wdata_i;
      if (addr_i == OFS_AUX_ONE) aux_reg <= wdata_i;
      if (addr_i == OFS_RUN_FLAGS) run_reg <= {wdata_i[BIT_T1_RUN], wdata_i[BIT_T0_RUN]};
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_rd(a);
    rd_i && addr_i == a;
  endsequence
  // software writes excluded so only hardware sets count here
  sequence s_hw_rise(f);
    $rose(f) && !$past(wr_i);
  endsequence
  property p_idle_zero;
    !rd_i |=> rdata_o == 8'h00;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data not zero outside read");
  property p_unmapped;
    rd_i && !mapped |=> rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_mode_rb;
    s_rd(OFS_MODE) |=> rdata_o == $past(mode_reg);
  endproperty
  a_mode_rb: assert property (p_mode_rb) else $error("mode readback wrong");
  property p_aux_rb;
    s_rd(OFS_AUX_ONE) |=> rdata_o == $past(aux_reg);
  endproperty
  a_aux_rb: assert property (p_aux_rb) else $error("aux readback wrong");
  property p_flag_rb;
    s_rd(OFS_RUN_FLAGS) |=> rdata_o == {$past(t1_overflow_flag_o), $past(run_reg[1]),
                                        $past(t0_overflow_flag_o), $past(run_reg[0]), 4'h0};
  endproperty
  a_flag_rb: assert property (p_flag_rb) else $error("run/flag readback wrong");
  property p_t0_fall;
    $fell(t0_overflow_flag_o) |-> $past(t0_vector_ack_i) || $past(wr_i && addr_i == OFS_RUN_FLAGS);
  endproperty
  a_t0_fall: assert property (p_t0_fall) else $error("timer0 flag cleared without cause");
  property p_t1_fall;
    $fell(t1_overflow_flag_o) |-> $past(t1_vector_ack_i) || $past(wr_i && addr_i == OFS_RUN_FLAGS);
  endproperty
  a_t1_fall: assert property (p_t1_fall) else $error("timer1 flag cleared without cause");
  property p_t0_rise_run;
    s_hw_rise(t0_overflow_flag_o) |-> $past(run_reg[0]);
  endproperty
  a_t0_rise_run: assert property (p_t0_rise_run) else $error("timer0 overflow while stopped");
  property p_t1_rise_run;
    s_hw_rise(t1_overflow_flag_o) |-> $past(run_reg[1]);
  endproperty
  a_t1_rise_run: assert property (p_t1_rise_run) else $error("timer1 overflow while stopped");
  property p_t1_halt;
    s_hw_rise(t1_overflow_flag_o) |-> $past(mode_reg[5:4]) != MODE_SPLIT || $past(mode_reg[1:0]) == MODE_SPLIT;
  endproperty
  a_t1_halt: assert property (p_t1_halt) else $error("halted timer1 raised its flag");
endmodule : dual_timer_counter_properties

bind dual_timer_counter dual_timer_counter_properties u_props (
  .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .ext_irq0_pin_i(ext_irq0_pin_i), .ext_irq1_pin_i(ext_irq1_pin_i),
  .t0_count_pin_i(t0_count_pin_i), .t1_count_pin_i(t1_count_pin_i), .slow_clk_i(slow_clk_i),
  .t0_vector_ack_i(t0_vector_ack_i), .t1_vector_ack_i(t1_vector_ack_i),
  .t0_overflow_flag_o(t0_overflow_flag_o), .t1_overflow_flag_o(t1_overflow_flag_o));

// File: tb/tb.sv
// self-checking bench for the dual timer/counter
// assumes the design package and a 40 MHz system clock
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb import dual_timer_pkg::*;;
  logic              clk_i;
  logic              rstn_i;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i;
  logic              wr_i;
  logic              rd_i;
  logic [DATA_W-1:0] rdata_o;
  logic              irq0, irq1, t0p, t1p, slow, ack0, ack1, f0, f1;
  int                mismatches;
  int                checks_done;
  int                cycles;
  localparam logic [7:0] REGS [7] = '{OFS_RUN_FLAGS, OFS_MODE, OFS_T0_LOW, OFS_T1_LOW,
                                      OFS_T0_HIGH, OFS_T1_HIGH, OFS_AUX_ONE};

  dual_timer_counter dut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_irq0_pin_i(irq0), .ext_irq1_pin_i(irq1),
    .t0_count_pin_i(t0p), .t1_count_pin_i(t1p), .slow_clk_i(slow), .t0_vector_ack_i(ack0),
    .t1_vector_ack_i(ack1), .t0_overflow_flag_o(f0), .t1_overflow_flag_o(f1));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // a few hundred cycles per scenario is ample
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // bus and pin tasks
  // ----------------------------------------------------------------
  task automatic bus_wr(input logic [7:0] a, d);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, e, input string n);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    `CHK(n, e, rdata_o)
  endtask : bus_rd

  // pulses held 4 clocks, wider than the 2 clocks the sampler needs
  task automatic pulses(input logic [2:0] m, input int n);
    repeat (n) begin
      @(posedge clk_i);
      {slow, t1p, t0p} <= ~m;
      repeat (4) @(posedge clk_i);
      {slow, t1p, t0p} <= 3'b111;
      repeat (3) @(posedge clk_i);
    end
  endtask : pulses

  // run both timers for exactly 2k clocks, so k base ticks whatever the phase
  task automatic run_both(input logic [7:0] m, l0, h0, l1, h1, input int k,
                          input logic [7:0] el0, eh0, el1, eh1, input logic [1:0] ef);
    bus_wr(OFS_MODE, m);
    bus_wr(OFS_T0_LOW, l0);
    bus_wr(OFS_T0_HIGH, h0);
    bus_wr(OFS_T1_LOW, l1);
    bus_wr(OFS_T1_HIGH, h1);
    bus_wr(OFS_RUN_FLAGS, 8'h50);
    repeat (2 * k - 2) @(posedge clk_i);
    @(negedge clk_i);
    `CHK("flags", ef, {f1, f0})
    bus_wr(OFS_RUN_FLAGS, 8'h00);
    repeat (4) @(posedge clk_i);
    bus_rd(OFS_T0_LOW, el0, "t0 low");
    bus_rd(OFS_T0_HIGH, eh0, "t0 high");
    bus_rd(OFS_T1_LOW, el1, "t1 low");
    bus_rd(OFS_T1_HIGH, eh1, "t1 high");
  endtask : run_both

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    foreach (REGS[i]) bus_rd(REGS[i], 8'h00, "reset value");
    for (int i = 1; i < 7; i++) bus_wr(REGS[i], REGS[i] ^ 8'h5a);
    for (int i = 1; i < 7; i++) bus_rd(REGS[i], REGS[i] ^ 8'h5a, "readback");
    bus_wr(8'h8e, 8'hff);
    bus_rd(8'h8e, 8'h00, "unmapped");
    bus_wr(OFS_AUX_ONE, 8'h00);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_modes();
    run_both(8'h00, 8'hfe, 8'hff, 8'hfe, 8'hff, 4, 8'he2, 8'h00, 8'he2, 8'h00, 2'b11);
    run_both(8'h11, 8'hfe, 8'hff, 8'hfe, 8'hff, 4, 8'h02, 8'h00, 8'h02, 8'h00, 2'b11);
    run_both(8'h22, 8'hfe, 8'hf0, 8'hfe, 8'hf0, 4, 8'hf2, 8'hf0, 8'hf2, 8'hf0, 2'b11);
    run_both(8'h30, 8'h00, 8'h00, 8'hfe, 8'hff, 4, 8'h04, 8'h00, 8'hfe, 8'hff, 2'b00);
    run_both(8'h33, 8'h00, 8'hfe, 8'hfe, 8'hfe, 4, 8'h04, 8'h02, 8'hfe, 8'hfe, 2'b10);
    run_both(8'h13, 8'h00, 8'h00, 8'hfe, 8'hff, 4, 8'h04, 8'h04, 8'h02, 8'h00, 2'b00);
    run_both(8'h11, 8'h00, 8'h00, 8'h00, 8'h00, 20, 8'h14, 8'h00, 8'h14, 8'h00, 2'b00);
    $display("t_modes done");
  endtask : t_modes

  task automatic t_gate();
    @(posedge clk_i);
    irq0 <= 1'b0;
    irq1 <= 1'b0;
    run_both(8'h99, 8'h00, 8'h00, 8'h00, 8'h00, 4, 8'h00, 8'h00, 8'h00, 8'h00, 2'b00);
    @(posedge clk_i);
    irq0 <= 1'b1;
    run_both(8'h99, 8'h00, 8'h00, 8'h00, 8'h00, 4, 8'h04, 8'h00, 8'h00, 8'h00, 2'b00);
    @(posedge clk_i);
    irq0 <= 1'b0;
    irq1 <= 1'b1;
    run_both(8'h99, 8'h00, 8'h00, 8'h00, 8'h00, 4, 8'h00, 8'h00, 8'h04, 8'h00, 2'b00);
    @(posedge clk_i);
    irq0 <= 1'b1;
    $display("t_gate done");
  endtask : t_gate

  // slow source: 32 falls give two counts whatever the divider phase
  task automatic t_counter();
    bus_wr(OFS_MODE, 8'h55);
    bus_wr(OFS_T0_LOW, 8'h00);
    bus_wr(OFS_T1_LOW, 8'h00);
    bus_wr(OFS_RUN_FLAGS, 8'h50);
    pulses(3'b011, 3);
    pulses(3'b010, 2);
    bus_wr(OFS_AUX_ONE, 8'h02);
    pulses(3'b110, 32);
    bus_wr(OFS_RUN_FLAGS, 8'h00);
    bus_rd(OFS_T0_LOW, 8'h03, "t0 events");
    bus_rd(OFS_T1_LOW, 8'h07, "t1 events");
    bus_wr(OFS_AUX_ONE, 8'h00);
    $display("t_counter done");
  endtask : t_counter

  task automatic t_ack();
    bus_wr(OFS_RUN_FLAGS, 8'ha0);
    bus_rd(OFS_RUN_FLAGS, 8'ha0, "flags set");
    @(posedge clk_i);
    ack0 <= 1'b1;
    @(posedge clk_i);
    ack0 <= 1'b0;
    @(negedge clk_i);
    `CHK("ack t0", 2'b10, {f1, f0})
    @(posedge clk_i);
    ack1 <= 1'b1;
    @(posedge clk_i);
    ack1 <= 1'b0;
    @(negedge clk_i);
    `CHK("ack t1", 2'b00, {f1, f0})
    $display("t_ack done");
  endtask : t_ack

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    rstn_i      = 1'b0;
    addr_i      = 8'h00;
    wdata_i     = 8'h00;
    wr_i        = 1'b0;
    rd_i        = 1'b0;
    {irq0, irq1, t0p, t1p, slow} = 5'h1f;
    {ack0, ack1} = 2'b00;
    mismatches  = 0;
    checks_done = 0;
    cycles      = 0;
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_regs();
    t_modes();
    t_gate();
    t_counter();
    t_ack();
    tally_and_finish();
  end
endmodule : tb

// File: verilog/dual_timer_counter.sv
// two compatible timer/counters with byte register port
// assumes single system clock; slow clock and pins arrive asynchronously
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps

module dual_timer_counter
  import dual_timer_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  // register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  // pins
  input  wire logic              ext_irq0_pin_i,
  input  wire logic              ext_irq1_pin_i,
  input  wire logic              t0_count_pin_i,
  input  wire logic              t1_count_pin_i,
  input  wire logic              slow_clk_i,
  // interrupt controller side
  input  wire logic              t0_vector_ack_i,
  input  wire logic              t1_vector_ack_i,
  output logic                   t0_overflow_flag_o,
  output logic                   t1_overflow_flag_o
);

  // ----------------------------------------------------------------
  // arithmetic helpers
  // ----------------------------------------------------------------
  // returns {overflow, byte+1}
  function automatic logic [8:0] inc8(input logic [7:0] val);
    inc8 = {1'b0, val} + 9'h001;
  endfunction : inc8

  // one count step in modes 00..10; returns {overflow, high, low}
  function automatic logic [16:0] timer_step(input timer_mode_t m,
                                             input logic [7:0]  lo,
                                             input logic [7:0]  hi);
    logic [7:0]            nlo;
    logic [7:0]            nhi;
    logic                  ovf;
    logic [PRESCALE_W-1:0] pre;
    nlo = lo;
    nhi = hi;
    ovf = 1'b0;
    pre = lo[PRESCALE_W-1:0];
    unique case (m)
      MODE_PRESCALED: begin
        // upper low-byte bits are left alone
        nlo[PRESCALE_W-1:0] = pre + 1'b1;
        if (&pre) begin
          {ovf, nhi} = inc8(hi);
        end
      end
      MODE_WIDE: begin
        {ovf, nhi, nlo} = {1'b0, hi, lo} + 17'h00001;
      end
      MODE_RELOAD: begin
        if (&lo) begin
          nlo = hi;
          ovf = 1'b1;
        end else begin
          nlo = lo + 8'h01;
        end
      end
      MODE_SPLIT: begin
        nlo = lo;
      end
    endcase
    timer_step = {ovf, nhi, nlo};
  endfunction : timer_step

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mode_reg;
  logic [DATA_W-1:0] aux_reg;
  logic              t0_run_reg;
  logic              t1_run_reg;
  logic              tf0_reg;
  logic              tf1_reg;
  logic [7:0]        tl0_reg;
  logic [7:0]        th0_reg;
  logic [7:0]        tl1_reg;
  logic [7:0]        th1_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic              base_reg;
  logic [3:0]        slow_cnt_reg;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic irq0_lvl;
  logic irq1_lvl;
  logic t0_fall;
  logic t1_fall;
  logic slow_fall;

  pin_edge_sync u_sync_irq0 (
    .clk_i(clk_i), .rstn_i(rstn_i), .pin_i(ext_irq0_pin_i), .level_o(irq0_lvl), .fall_o()
  );

  pin_edge_sync u_sync_irq1 (
    .clk_i(clk_i), .rstn_i(rstn_i), .pin_i(ext_irq1_pin_i), .level_o(irq1_lvl), .fall_o()
  );

  // pulses narrower than 2 clocks may be missed
  pin_edge_sync u_sync_t0 (
    .clk_i(clk_i), .rstn_i(rstn_i), .pin_i(t0_count_pin_i), .level_o(), .fall_o(t0_fall)
  );

  pin_edge_sync u_sync_t1 (
    .clk_i(clk_i), .rstn_i(rstn_i), .pin_i(t1_count_pin_i), .level_o(), .fall_o(t1_fall)
  );

  pin_edge_sync u_sync_slow (
    .clk_i(clk_i), .rstn_i(rstn_i), .pin_i(slow_clk_i), .level_o(), .fall_o(slow_fall)
  );

  // ----------------------------------------------------------------
  // time bases
  // ----------------------------------------------------------------
  logic base_tick;
  logic slow_tick;

  assign base_tick = (base_reg == 1'(TIMEBASE_CYCLES - 1));
  assign slow_tick = slow_fall & (slow_cnt_reg == 4'(SLOW_DIV - 1));

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      base_reg <= 1'b0;
    end else begin
      base_reg <= ~base_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      slow_cnt_reg <= 4'h0;
    end else if (slow_fall) begin
      slow_cnt_reg <= slow_cnt_reg + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // count enables
  // ----------------------------------------------------------------
  timer_mode_t t0_mode;
  timer_mode_t t1_mode;
  logic        t0_enable;
  logic        t1_enable;
  logic        t1_source;
  logic        t0_inc;
  logic        t1_inc;
  logic        th0_split_inc;

  assign t0_mode   = timer_mode_t'(mode_reg[T0_MODE_LSB +: 2]);
  assign t1_mode   = timer_mode_t'(mode_reg[T1_MODE_LSB +: 2]);
  assign t0_enable = t0_run_reg & (~mode_reg[BIT_T0_GATE] | irq0_lvl);
  assign t1_enable = t1_run_reg & (~mode_reg[BIT_T1_GATE] | irq1_lvl);
  assign t1_source = aux_reg[BIT_T1_SOURCE] ? slow_tick : t1_fall;
  assign t0_inc    = t0_enable & (mode_reg[BIT_T0_CSEL] ? t0_fall : base_tick);
  assign t1_inc    = t1_enable & (mode_reg[BIT_T1_CSEL] ? t1_source : base_tick);
  // split high byte runs off the timer1 run bit alone
  assign th0_split_inc = (t0_mode == MODE_SPLIT) & t1_run_reg & base_tick;

  // ----------------------------------------------------------------
  // next count values
  // ----------------------------------------------------------------
  logic [16:0] t0_step;
  logic [16:0] t1_step;
  logic [8:0]  tl0_split;
  logic [8:0]  th0_split;
  logic        t0_ovf;
  logic        t1_ovf;
  logic        th0_ovf;
  logic [7:0]  tl0_next;
  logic [7:0]  th0_next;
  logic [7:0]  tl1_next;
  logic [7:0]  th1_next;

  assign t0_step   = timer_step(t0_mode, tl0_reg, th0_reg);
  assign t1_step   = timer_step(t1_mode, tl1_reg, th1_reg);
  assign tl0_split = inc8(tl0_reg);
  assign th0_split = inc8(th0_reg);

  always_comb begin
    tl0_next = tl0_reg;
    th0_next = th0_reg;
    t0_ovf   = 1'b0;
    th0_ovf  = 1'b0;
    if (t0_mode == MODE_SPLIT) begin
      if (t0_inc) begin
        tl0_next = tl0_split[7:0];
        t0_ovf   = tl0_split[8];
      end
      if (th0_split_inc) begin
        th0_next = th0_split[7:0];
        th0_ovf  = th0_split[8];
      end
    end else if (t0_inc) begin
      {t0_ovf, th0_next, tl0_next} = t0_step;
    end
  end

  always_comb begin
    tl1_next = tl1_reg;
    th1_next = th1_reg;
    t1_ovf   = 1'b0;
    // mode 11 holds timer1 still
    if (t1_inc && t1_mode != MODE_SPLIT) begin
      {t1_ovf, th1_next, tl1_next} = t1_step;
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  logic wr_run;
  logic wr_mode;
  logic wr_aux;

  assign wr_run  = wr_i & (addr_i == OFS_RUN_FLAGS);
  assign wr_mode = wr_i & (addr_i == OFS_MODE);
  assign wr_aux  = wr_i & (addr_i == OFS_AUX_ONE);

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      mode_reg <= RESET_BYTE;
      aux_reg  <= RESET_BYTE;
    end else begin
      if (wr_mode) begin
        mode_reg <= wdata_i;
      end
      if (wr_aux) begin
        aux_reg <= wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      t0_run_reg <= 1'b0;
      t1_run_reg <= 1'b0;
    end else if (wr_run) begin
      t0_run_reg <= wdata_i[BIT_T0_RUN];
      t1_run_reg <= wdata_i[BIT_T1_RUN];
    end
  end

  // ----------------------------------------------------------------
  // overflow flags: a hardware set beats any clear
  // ----------------------------------------------------------------
  logic tf1_set;

  // timer1 loses its flag to the split high byte
  assign tf1_set = (t0_mode == MODE_SPLIT) ? th0_ovf : t1_ovf;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      tf0_reg <= 1'b0;
    end else if (t0_ovf) begin
      tf0_reg <= 1'b1;
    end else if (t0_vector_ack_i) begin
      tf0_reg <= 1'b0;
    end else if (wr_run) begin
      tf0_reg <= wdata_i[BIT_T0_FLAG];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      tf1_reg <= 1'b0;
    end else if (tf1_set) begin
      tf1_reg <= 1'b1;
    end else if (t1_vector_ack_i) begin
      tf1_reg <= 1'b0;
    end else if (wr_run) begin
      tf1_reg <= wdata_i[BIT_T1_FLAG];
    end
  end

  // ----------------------------------------------------------------
  // count bytes: software write beats counting that cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      tl0_reg <= RESET_BYTE;
      th0_reg <= RESET_BYTE;
    end else begin
      tl0_reg <= (wr_i && addr_i == OFS_T0_LOW) ? wdata_i : tl0_next;
      th0_reg <= (wr_i && addr_i == OFS_T0_HIGH) ? wdata_i : th0_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      tl1_reg <= RESET_BYTE;
      th1_reg <= RESET_BYTE;
    end else begin
      tl1_reg <= (wr_i && addr_i == OFS_T1_LOW) ? wdata_i : tl1_next;
      th1_reg <= (wr_i && addr_i == OFS_T1_HIGH) ? wdata_i : th1_next;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] run_flags_view;

  always_comb begin
    run_flags_view              = RESET_BYTE;
    run_flags_view[BIT_T1_FLAG] = tf1_reg;
    run_flags_view[BIT_T1_RUN]  = t1_run_reg;
    run_flags_view[BIT_T0_FLAG] = tf0_reg;
    run_flags_view[BIT_T0_RUN]  = t0_run_reg;
  end

  // unmapped addresses read zero
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rdata_reg <= RESET_BYTE;
    end else if (rd_i) begin
      unique case (addr_i)
        OFS_RUN_FLAGS: rdata_reg <= run_flags_view;
        OFS_MODE:      rdata_reg <= mode_reg;
        OFS_T0_LOW:    rdata_reg <= tl0_reg;
        OFS_T1_LOW:    rdata_reg <= tl1_reg;
        OFS_T0_HIGH:   rdata_reg <= th0_reg;
        OFS_T1_HIGH:   rdata_reg <= th1_reg;
        OFS_AUX_ONE:   rdata_reg <= aux_reg;
        default:       rdata_reg <= RESET_BYTE;
      endcase
    end else begin
      rdata_reg <= RESET_BYTE;
    end
  end

  assign rdata_o            = rdata_reg;
  assign t0_overflow_flag_o = tf0_reg;
  assign t1_overflow_flag_o = tf1_reg;

endmodule : dual_timer_counter

// File: verilog/dual_timer_pkg.sv
// constants, field layout and mode codes of the dual timer/counter block
// assumes a byte-wide register port and one system clock
package dual_timer_pkg;

  // ----------------------------------------------------------------
  // register port geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_RUN_FLAGS = 8'h88;
  localparam logic [ADDR_W-1:0] OFS_MODE      = 8'h89;
  localparam logic [ADDR_W-1:0] OFS_T0_LOW    = 8'h8a;
  localparam logic [ADDR_W-1:0] OFS_T1_LOW    = 8'h8b;
  localparam logic [ADDR_W-1:0] OFS_T0_HIGH   = 8'h8c;
  localparam logic [ADDR_W-1:0] OFS_T1_HIGH   = 8'h8d;
  localparam logic [ADDR_W-1:0] OFS_AUX_ONE   = 8'hf8;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_T1_FLAG   = 7;
  localparam int unsigned BIT_T1_RUN    = 6;
  localparam int unsigned BIT_T0_FLAG   = 5;
  localparam int unsigned BIT_T0_RUN    = 4;
  localparam int unsigned BIT_T1_GATE   = 7;
  localparam int unsigned BIT_T1_CSEL   = 6;
  localparam int unsigned T1_MODE_LSB   = 4;
  localparam int unsigned BIT_T0_GATE   = 3;
  localparam int unsigned BIT_T0_CSEL   = 2;
  localparam int unsigned T0_MODE_LSB   = 0;
  localparam int unsigned BIT_T1_SOURCE = 1;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RESET_BYTE      = 8'h00;
  localparam int unsigned       TIMEBASE_CYCLES = 2;
  localparam int unsigned       SLOW_DIV        = 16;
  localparam int unsigned       PRESCALE_W      = 5;

  // ----------------------------------------------------------------
  // timer modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_PRESCALED = 2'b00,
    MODE_WIDE      = 2'b01,
    MODE_RELOAD    = 2'b10,
    MODE_SPLIT     = 2'b11
  } timer_mode_t;

endpackage : dual_timer_pkg

// File: verilog/pin_edge_sync.sv
// two-stage synchroniser with falling-edge detector for one pin
// assumes the pin is asynchronous to clk_i
`timescale 1ns/1ps
module pin_edge_sync (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // pin side
  input  wire logic pin_i,
  // synchronised side
  output logic      level_o,
  output logic      fall_o
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // first stage feeds only the second one
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level_o = sync_reg;
  assign fall_o  = prev_reg & ~sync_reg;

endmodule : pin_edge_sync
